// [src/urdr_pkg.sv]
// receive data recovery: shared constants, state type and vote helpers
// assumes a 100 MHz pclk and a 32-bit apb slave with byte addresses
package urdr_pkg;
   // register byte offsets
   localparam logic [7:0]  OFF_CTRL   = 8'h00;
   localparam logic [7:0]  OFF_STAT   = 8'h04;
   localparam logic [7:0]  OFF_MASK   = 8'h08;
   localparam logic [7:0]  OFF_DATA   = 8'h0C;
   // control fields: divisor in bits 15:0
   localparam int          CTRL_WORD9 = 16;
   localparam int          CTRL_RXEN  = 17;
   // status and mask fields
   localparam int          ST_FULL    = 0;
   localparam int          ST_NOISE   = 1;
   localparam int          ST_FE      = 2;
   // reset values
   localparam logic [15:0] DIV_RST    = 16'h0035;
   localparam logic        WORD9_RST  = 1'b0;
   localparam logic        RXEN_RST   = 1'b0;
   localparam logic [2:0]  STAT_RST   = 3'h0;
   localparam logic [2:0]  MASK_RST   = 3'h0;
   // sample tick positions within a bit, edge age limit and no-edge value
   localparam logic [4:0]  RT_BIT     = 5'h10;
   localparam logic [4:0]  RT_V1      = 5'h03;
   localparam logic [4:0]  RT_V2      = 5'h05;
   localparam logic [4:0]  RT_V3      = 5'h07;
   localparam logic [4:0]  RT_M1      = 5'h08;
   localparam logic [4:0]  RT_M2      = 5'h09;
   localparam logic [4:0]  RT_M3      = 5'h0A;
   localparam logic [4:0]  EDGE_MAX   = 5'h0D;
   localparam logic [4:0]  EDGE_NONE  = 5'h1F;
   // ticks from start edge to first stop sample, and last data bit index
   localparam logic [7:0]  LEAD8      = 8'h97;
   localparam logic [7:0]  LEAD9      = 8'hA7;
   localparam logic [3:0]  LAST8      = 4'h7;
   localparam logic [3:0]  LAST9      = 4'h8;

   typedef enum logic [1:0] {st_hunt, st_start, st_data, st_stop} urdr_state_e;

   // majority of three samples
   function automatic logic maj3(input logic [2:0] s);
      maj3 = (s[2] & s[1]) | (s[2] & s[0]) | (s[1] & s[0]);
   endfunction

   // samples disagree
   function automatic logic split3(input logic [2:0] s);
      split3 = (s != 3'h0) && (s != 3'h7);
   endfunction
endpackage

// [src/urdr_tick_if.sv]
// tick request and oversampling tick between core and divider
// assumes one clock domain
`timescale 1ns/1ns
`default_nettype none
interface urdr_tick_if;
   logic [15:0] divisor;
   logic        enable;
   logic        tick;
   modport gen (input divisor, input enable, output tick);
   modport ctl (output divisor, output enable, input tick);
endinterface
`default_nettype wire

// [src/urdr_tick_gen.sv]
// sixteen-times-baud tick divider: one-cycle pulse every divisor+1 clocks
// assumes divisor stable while enabled
`timescale 1ns/1ns
`default_nettype none
module urdr_tick_gen (
   input  wire logic  pclk,
   input  wire logic  presetn,
   urdr_tick_if.gen   t
);
   typedef struct packed {
      logic [15:0] cnt;
      logic        tick;
   } urdr_div_s;

   urdr_div_s r;
   urdr_div_s n;

   always_comb begin
      n = r;
      n.tick = 1'b0;
      if (!t.enable) begin
         n.cnt = 16'h0000;
      end else if (r.cnt >= t.divisor) begin
         n.cnt = 16'h0000;
         n.tick = 1'b1;
      end else begin
         n.cnt = r.cnt + 16'h0001;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '{cnt: 16'h0000, tick: 1'b0};
      end else begin
         r <= n;
      end
   end

   assign t.tick = r.tick;
endmodule
`default_nettype wire

// [src/urdr_edge_hunt.sv]
// receive line history on each tick; flags falling edges
// assumes rxd synchronous to pclk
`timescale 1ns/1ns
`default_nettype none
module urdr_edge_hunt (
   input  wire logic  pclk,
   input  wire logic  presetn,
   input  wire logic  tick,
   input  wire logic  rxd,
   output logic       fall3,
   output logic       fall
);
   typedef struct packed {
      logic [2:0] hist;
   } urdr_hist_s;

   urdr_hist_s r;
   urdr_hist_s n;

   always_comb begin
      n = r;
      if (tick) begin
         n.hist = {r.hist[1:0], rxd};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '{hist: 3'h7};
      end else begin
         r <= n;
      end
   end

   // fall3: low after three highs; fall: low after one high
   assign fall3 = tick & ~rxd & (r.hist == 3'h7);
   assign fall  = tick & ~rxd & r.hist[0];
endmodule
`default_nettype wire

// [src/urdr_core.sv]
// receive data recovery core with apb registers and interrupt
// assumes rxd synchronous to pclk and an apb master at 100 MHz
// Overview of operation
// - line sampled on a tick at sixteen times baud, sixteen per bit
// - tick count realigned only after one-to-zero changes between data bits
// - start hunt: low after three highs starts the tick count
// - start kept only if at most one of ticks three, five, seven high
// - accepted start with exactly one high verify sample sets noise
// - failed start verify resets count, resumes hunt, no noise
// - data bit is majority of ticks eight, nine, ten
// - disagreeing mid-bit samples set noise
// - high start mid-bit samples set noise, start still kept
// - stop majority low sets framing error; disagreement sets noise
// - missing stop, break included, sets framing error in status
// - framing error set in same cycle as receive full
// - glitches rejected before start acceptance never set noise
// - without realignment, stop sampling starts 151 ticks after edge, 167 for nine bits
// - word length bit picks eight or nine data bits; ninth lands in data bit 8
// - finished frame loads data register and sets receive full
`timescale 1ns/1ns
`default_nettype none
module urdr_core (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        rxd,
   output logic             irq
);
   typedef struct packed {
      urdr_pkg::urdr_state_e state;
      logic [4:0]            rt;
      logic [2:0]            smp;
      logic [3:0]            bitn;
      logic [8:0]            shreg;
      logic                  prev1;
      logic                  decided;
      logic                  noise_acc;
      logic                  resynced;
      logic [4:0]            edge_ago;
      logic [7:0]            since;
      logic [15:0]           divisor;
      logic                  word9;
      logic                  rx_en;
      logic [2:0]            status;
      logic [2:0]            mask;
      logic [8:0]            data;
   } urdr_core_s;

   urdr_core_s  r;
   urdr_core_s  n;
   urdr_tick_if tk ();
   logic        tick;
   logic        fall3;
   logic        fall;
   logic [4:0]  cur;
   logic [2:0]  trip;
   logic        vote;
   logic        mixed;
   logic        done;
   logic        resync;
   logic        wr;
   logic        mapped;
   logic [2:0]  set;
   logic [2:0]  clr;

   urdr_tick_gen u_tick (
      .pclk    (pclk),
      .presetn (presetn),
      .t       (tk)
   );

   urdr_edge_hunt u_hunt (
      .pclk    (pclk),
      .presetn (presetn),
      .tick    (tick),
      .rxd     (rxd),
      .fall3   (fall3),
      .fall    (fall)
   );

   assign tk.divisor = r.divisor;
   assign tk.enable  = r.rx_en;
   assign tick       = tk.tick;

   assign trip  = {r.smp[1:0], rxd};
   assign vote  = urdr_pkg::maj3(trip);
   assign mixed = urdr_pkg::split3(trip);
   assign wr    = psel & penable & pwrite;

   always_comb begin
      n      = r;
      done   = 1'b0;
      resync = 1'b0;
      set    = 3'h0;
      clr    = 3'h0;
      cur    = (r.rt == urdr_pkg::RT_BIT) ? 5'h01 : r.rt + 5'h01;
      // register writes
      if (wr) begin
         unique case (paddr)
            urdr_pkg::OFF_CTRL: begin
               n.divisor = pwdata[15:0];
               n.word9   = pwdata[urdr_pkg::CTRL_WORD9];
               n.rx_en   = pwdata[urdr_pkg::CTRL_RXEN];
            end
            urdr_pkg::OFF_STAT: begin
               clr = pwdata[2:0];
            end
            urdr_pkg::OFF_MASK: begin
               n.mask = pwdata[2:0];
            end
            default: begin
            end
         endcase
      end
      if (tick && r.state != urdr_pkg::st_hunt) begin
         n.rt    = cur;
         n.since = r.since + 8'h01;
      end
      if (tick) begin
         if (fall) begin
            n.edge_ago = 5'h00;
         end else if (r.edge_ago != urdr_pkg::EDGE_NONE) begin
            n.edge_ago = r.edge_ago + 5'h01;
         end
      end
      unique case (r.state)
         urdr_pkg::st_hunt: begin
            if (r.rx_en && fall3) begin
               n.state     = urdr_pkg::st_start;
               n.rt        = 5'h01;
               n.since     = 8'h00;
               n.noise_acc = 1'b0;
               n.resynced  = 1'b0;
               n.decided   = 1'b0;
               n.bitn      = 4'h0;
            end
         end
         urdr_pkg::st_start: begin
            if (tick) begin
               if (cur == urdr_pkg::RT_V1 || cur == urdr_pkg::RT_V2) begin
                  n.smp = trip;
               end
               if (cur == urdr_pkg::RT_V3) begin
                  if (vote) begin
                     n.state = urdr_pkg::st_hunt;
                     n.rt    = 5'h00;
                  end else if (mixed) begin
                     n.noise_acc = 1'b1;
                  end
               end
               if (cur >= urdr_pkg::RT_M1 && cur <= urdr_pkg::RT_M3 && rxd) begin
                  n.noise_acc = 1'b1;
               end
               if (cur == urdr_pkg::RT_BIT) begin
                  n.state = urdr_pkg::st_data;
                  n.prev1 = 1'b0;
               end
            end
         end
         urdr_pkg::st_data: begin
            if (tick) begin
               if ((cur == urdr_pkg::RT_M1 || cur == urdr_pkg::RT_M2) && !r.decided) begin
                  n.smp = trip;
               end
               if (cur == urdr_pkg::RT_M3 && !r.decided) begin
                  n.shreg   = {vote, r.shreg[8:1]};
                  n.prev1   = vote;
                  n.decided = 1'b1;
                  if (mixed) begin
                     n.noise_acc = 1'b1;
                  end
                  if (r.prev1 && !vote && !fall && r.edge_ago <= urdr_pkg::EDGE_MAX) begin
                     n.rt       = r.edge_ago + 5'h02;
                     n.resynced = 1'b1;
                     resync     = 1'b1;
                  end
               end
               if (cur == urdr_pkg::RT_BIT) begin
                  n.decided = 1'b0;
                  n.bitn    = r.bitn + 4'h1;
                  if (r.bitn == (r.word9 ? urdr_pkg::LAST9 : urdr_pkg::LAST8)) begin
                     n.state = urdr_pkg::st_stop;
                  end
               end
            end
         end
         urdr_pkg::st_stop: begin
            if (tick) begin
               if (cur == urdr_pkg::RT_M1 || cur == urdr_pkg::RT_M2) begin
                  n.smp = trip;
               end
               if (cur == urdr_pkg::RT_M3) begin
                  done    = 1'b1;
                  n.state = urdr_pkg::st_hunt;
                  n.rt    = 5'h00;
                  n.data  = r.word9 ? r.shreg : {1'b0, r.shreg[8:1]};
                  set[urdr_pkg::ST_FULL] = 1'b1;
                  set[urdr_pkg::ST_FE]    = ~vote;
                  set[urdr_pkg::ST_NOISE] = r.noise_acc | mixed;
               end
            end
         end
      endcase
      if (!r.rx_en) begin
         n.state = urdr_pkg::st_hunt;
         n.rt    = 5'h00;
      end
      // set wins over write-one clear
      n.status = (r.status & ~clr) | set;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '{state: urdr_pkg::st_hunt, rt: 5'h00, smp: 3'h0, bitn: 4'h0,
                shreg: 9'h000, prev1: 1'b0, decided: 1'b0, noise_acc: 1'b0,
                resynced: 1'b0, edge_ago: urdr_pkg::EDGE_NONE, since: 8'h00,
                divisor: urdr_pkg::DIV_RST, word9: urdr_pkg::WORD9_RST,
                rx_en: urdr_pkg::RXEN_RST, status: urdr_pkg::STAT_RST,
                mask: urdr_pkg::MASK_RST, data: 9'h000};
      end else begin
         r <= n;
      end
   end

   // register read mux
   always_comb begin
      prdata = 32'h0000_0000;
      mapped = 1'b1;
      unique case (paddr)
         urdr_pkg::OFF_CTRL: begin
            prdata[15:0] = r.divisor;
            prdata[urdr_pkg::CTRL_WORD9] = r.word9;
            prdata[urdr_pkg::CTRL_RXEN]  = r.rx_en;
         end
         urdr_pkg::OFF_STAT: begin
            prdata[2:0] = r.status;
         end
         urdr_pkg::OFF_MASK: begin
            prdata[2:0] = r.mask;
         end
         urdr_pkg::OFF_DATA: begin
            prdata[8:0] = r.data;
         end
         default: begin
            mapped = 1'b0;
         end
      endcase
   end

   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~mapped;
   assign irq     = |(r.status & r.mask);

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   start_arm_a: assert property (
      r.state == urdr_pkg::st_hunt && r.rx_en && fall3
      |=> r.state == urdr_pkg::st_start && r.rt == 5'h01 && r.since == 8'h00)
      else $error("start edge did not arm count");

   verify_fail_a: assert property (
      r.state == urdr_pkg::st_start && tick && cur == urdr_pkg::RT_V3 && vote && r.rx_en
      |=> r.state == urdr_pkg::st_hunt && !r.noise_acc)
      else $error("failed start not rejected quietly");

   start_noise_a: assert property (
      r.state == urdr_pkg::st_start && tick && cur == urdr_pkg::RT_V3 && !vote && mixed
      && r.rx_en |=> r.noise_acc && r.state == urdr_pkg::st_start)
      else $error("noisy start did not mark noise");

   start_mid_a: assert property (
      r.state == urdr_pkg::st_start && tick && cur == urdr_pkg::RT_M2 && rxd && r.rx_en
      |=> r.noise_acc && r.state == urdr_pkg::st_start)
      else $error("start mid sample mishandled");

   data_vote_a: assert property (
      r.state == urdr_pkg::st_data && tick && cur == urdr_pkg::RT_M3 && !r.decided
      && r.rx_en |=> r.shreg[8] == $past(vote) && r.prev1 == $past(vote))
      else $error("data bit not majority");

   realign_a: assert property (
      resync && r.rx_en |=> r.rt == $past(r.edge_ago) + 5'h02)
      else $error("count not realigned to edge");

   stop_lead_a: assert property (
      r.state == urdr_pkg::st_stop && tick && cur == urdr_pkg::RT_M1 && !r.resynced
      |-> n.since == (r.word9 ? urdr_pkg::LEAD9 : urdr_pkg::LEAD8))
      else $error("stop sampled at wrong tick");

   fe_full_a: assert property (
      done && !vote |=> r.status[urdr_pkg::ST_FE] && r.status[urdr_pkg::ST_FULL]
      && r.data == $past(n.data))
      else $error("framing error not set with full");

   int_level_a: assert property (
      r.status[urdr_pkg::ST_FULL] && r.mask[urdr_pkg::ST_FULL] |-> irq)
      else $error("masked-in event without interrupt");

   hunt_rest_a: assert property (
      r.state == urdr_pkg::st_hunt |-> r.rt == 5'h00)
      else $error("tick count not cleared while hunting");

   arm_cause_a: assert property (
      r.state == urdr_pkg::st_hunt ##1 r.state == urdr_pkg::st_start
      |-> $past(fall3) && $past(r.rx_en))
      else $error("count armed without falling edge");

   quiet_arm_a: assert property (
      r.state == urdr_pkg::st_start && r.rt == 5'h01 |-> !r.noise_acc)
      else $error("noise carried into new start bit");

   frame_len_a: assert property (
      r.state == urdr_pkg::st_stop && tick && cur == urdr_pkg::RT_M3
      |-> r.bitn == (r.word9 ? urdr_pkg::LAST9 : urdr_pkg::LAST8) + 4'h1)
      else $error("wrong number of data bits");

   stop_noise_a: assert property (
      done && mixed |=> r.status[urdr_pkg::ST_NOISE])
      else $error("split stop samples without noise");

   full_load_a: assert property (
      done |=> r.status[urdr_pkg::ST_FULL] && (r.word9 || !r.data[8]))
      else $error("frame end without full or stray ninth bit");

   reject_c: cover property (
      r.state == urdr_pkg::st_start ##1 r.state == urdr_pkg::st_hunt);
   frame_c: cover property (done && vote && !r.noise_acc);
   break_c: cover property (done && !vote && r.shreg == 9'h000);
   resync_c: cover property (resync);
   noise_c: cover property (done && r.noise_acc);
endmodule
`default_nettype wire

// [tb/urdr_tx_model.sv]
// far-side serial transmitter model driving the receive line
// assumes rxd is sampled on pclk; one bit lasts per_clk cycles
`timescale 1ns/1ns
`default_nettype none
module urdr_tx_model (
   input  wire logic        pclk,
   input  wire logic        go,
   input  wire logic [8:0]  dat,
   input  wire logic        nine,
   input  wire logic        stop_v,
   input  wire logic [7:0]  per_clk,
   input  wire logic [3:0]  nz_bit,
   input  wire logic [15:0] nz_mask,
   output logic             rxd,
   output logic             busy
);
   logic [10:0] frm;
   logic        v;
   int          nb;

   initial begin
      rxd  = 1'b1;
      busy = 1'b0;
      forever begin
         do begin
            @(posedge pclk);
         end while (go !== 1'b1);
         busy <= 1'b1;
         nb = nine ? 11 : 10;
         frm = nine ? {stop_v, dat, 1'b0} : {1'b0, stop_v, dat[7:0], 1'b0};
         for (int b = 0; b < nb; b++) begin
            for (int c = 0; c < per_clk; c++) begin
               v = frm[b];
               if (b == nz_bit && c < 64 && nz_mask[c/4]) begin
                  v = !v;
               end
               rxd <= v;
               @(posedge pclk);
            end
         end
         rxd  <= 1'b1;
         busy <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// [tb/tb_urdr_core.sv]
// self-checking bench for the receive data recovery core
// assumes a zero-wait apb slave and the transmitter model on rxd
`timescale 1ns/1ns
`default_nettype none
module tb_urdr_core;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        rxd;
   logic        irq;
   logic        go;
   logic [8:0]  dat;
   logic        nine;
   logic        sv;
   logic [7:0]  per;
   logic [3:0]  nb;
   logic [15:0] nm;
   logic        busy;
   logic [31:0] rdat;
   logic        perr;
   logic [2:0]  q;
   logic [31:0] en8;
   int          h;
   int          lat;
   int          miscompares;
   int          check_count;

   urdr_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .rxd(rxd), .irq(irq));

   urdr_tx_model far (.pclk(pclk), .go(go), .dat(dat), .nine(nine), .stop_v(sv),
      .per_clk(per), .nz_bit(nb), .nz_mask(nm), .rxd(rxd), .busy(busy));

   always #5 pclk = ~pclk;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rdat = prdata;
      perr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rdat, e);
   endtask

   // clear status, send one frame, check status and data
   task automatic one(input logic [8:0] d, input logic s, input logic [7:0] p,
                      input logic [3:0] b, input logic [15:0] m,
                      input logic [31:0] es, input logic [31:0] ed);
      apb(1'b1, urdr_pkg::OFF_STAT, 32'h7);
      dat <= d;
      sv  <= s;
      per <= p;
      nb  <= b;
      nm  <= m;
      go  <= 1'b1;
      @(posedge pclk);
      go <= 1'b0;
      lat = 0;
      while (irq !== 1'b1 && lat < 900) begin
         @(posedge pclk);
         lat++;
      end
      while (busy !== 1'b0) begin
         @(posedge pclk);
      end
      repeat (80) @(posedge pclk);
      rc(urdr_pkg::OFF_STAT, es);
      rc(urdr_pkg::OFF_DATA, ed);
   endtask

   task automatic end_sim();
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (60000) @(posedge pclk);
      miscompares++;
      end_sim();
   end

   initial begin
      pclk        = 1'b0;
      presetn     = 1'b0;
      psel        = 1'b0;
      penable     = 1'b0;
      pwrite      = 1'b0;
      paddr       = 8'h00;
      pwdata      = 32'h0;
      go          = 1'b0;
      dat         = 9'h000;
      nine        = 1'b0;
      sv          = 1'b1;
      per         = 8'h40;
      nb          = 4'hF;
      nm          = 16'h0000;
      miscompares = 0;
      check_count = 0;
      en8 = (32'h1 << urdr_pkg::CTRL_RXEN) | 32'h3;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rc(urdr_pkg::OFF_CTRL, 32'h0000_0035);
      rc(urdr_pkg::OFF_STAT, 32'h0);
      rc(urdr_pkg::OFF_MASK, 32'h0);
      apb(1'b1, urdr_pkg::OFF_DATA, 32'h0000_01FF);
      rc(urdr_pkg::OFF_DATA, 32'h0);
      rc(8'h10, 32'h0);
      chk({31'h0, perr}, 32'h1);
      apb(1'b1, urdr_pkg::OFF_CTRL, en8);
      one(9'h0A5, 1'b1, 8'h40, 4'hF, 16'h0, 32'h1, 32'hA5);
      chk({31'h0, irq}, 32'h0);
      apb(1'b1, urdr_pkg::OFF_STAT, 32'h0);
      rc(urdr_pkg::OFF_STAT, 32'h1);
      apb(1'b1, urdr_pkg::OFF_MASK, 32'h1);
      chk({31'h0, irq}, 32'h1);
      apb(1'b1, urdr_pkg::OFF_STAT, 32'h1);
      chk({31'h0, irq}, 32'h0);
      apb(1'b1, urdr_pkg::OFF_MASK, 32'h7);
      one(9'h03C, 1'b1, 8'h40, 4'hF, 16'h0, 32'h1, 32'h3C);
      chk({31'h0, (lat >= 608 && lat <= 624)}, 32'h1);
      for (int p = 0; p < 8; p++) begin
         q = p[2:0];
         h = $countones(q);
         one(9'h0FF, 1'b1, 8'h40, 4'h1, {6'h0, q, 7'h0},
             {30'h0, h == 1 || h == 2, 1'b1}, {24'h0, 7'h7F, h < 2});
         one(9'h0FF, 1'b1, 8'h40, 4'h9, {6'h0, q, 7'h0},
             {29'h0, h >= 2, h == 1 || h == 2, 1'b1}, 32'hFF);
         one(9'h0FF, 1'b1, 8'h40, 4'h0, {9'h0, q[2], 1'b0, q[1], 1'b0, q[0], 2'b0},
             (h < 2) ? {30'h0, h == 1, 1'b1} : 32'h0, 32'hFF);
      end
      one(9'h0FF, 1'b1, 8'h40, 4'h0, 16'h0380, 32'h3, 32'hFF);
      nine <= 1'b1;
      apb(1'b1, urdr_pkg::OFF_CTRL, en8 | (32'h1 << urdr_pkg::CTRL_WORD9));
      one(9'h1A5, 1'b1, 8'h40, 4'hF, 16'h0, 32'h1, 32'h1A5);
      chk({31'h0, (lat >= 672 && lat <= 688)}, 32'h1);
      one(9'h000, 1'b0, 8'h40, 4'hF, 16'h0, 32'h5, 32'h0);
      nine <= 1'b0;
      apb(1'b1, urdr_pkg::OFF_CTRL, en8);
      one(9'h055, 1'b1, 8'h44, 4'hF, 16'h0, 32'h1, 32'h55);
      one(9'h0F0, 1'b1, 8'h3E, 4'hF, 16'h0, 32'h1, 32'hF0);
      end_sim();
   end
endmodule
`default_nettype wire
